// ===== core/lfa_apb_slave.sv
/*
 * Plain APB slave front end: decodes setup/access phases into one-cycle
 * write and read strobes with a word index. Zero wait states.
 * Assumes a single clock and a well-behaved APB master.
 */
`timescale 1ns/100ps
module lfa_apb_slave (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    output logic pready,
    output logic pslverr,
    output logic wr_stb,
    output logic rd_stb,
    output logic [11:0] idx
);
    // Every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign idx = paddr[13:2];
    assign wr_stb = psel & penable & pwrite;
    assign rd_stb = psel & penable & ~pwrite;
endmodule

// ===== core/lfa_pkg.sv
/*
 * Package for the lane FIFO alarm and sample timing register slice.
 * Holds register indices, reset values, field positions and the struct
 * that carries trim values to the converter cores.
 * Assumes APB with 32-bit data; printed offsets are register indices.
 */
package lfa_pkg;
    // Printed register offsets, used as word indices
    localparam logic [11:0] IDX_LANE_FLAGS = 12'h2c4;
    localparam logic [11:0] IDX_TRIM_A = 12'h310;
    localparam logic [11:0] IDX_TRIM_B = 12'h313;
    // Block-local registers
    localparam logic [11:0] IDX_SUMMARY = 12'h2c1;
    localparam logic [11:0] IDX_IRQ_STATUS = 12'h2f0;
    localparam logic [11:0] IDX_IRQ_MASK = 12'h2f1;
    localparam logic [11:0] IDX_MODE = 12'h2f2;
    // Field positions
    localparam int SUMMARY_FIFO_BIT = 5;
    localparam int MODE_DUAL_BIT = 0;
    localparam int MODE_FGCAL_BIT = 1;
    localparam int IRQ_LANE_BIT = 0;
    localparam int IRQ_SUMMARY_BIT = 1;
    // Widths and reset values
    localparam int LANES = 16;
    localparam int TRIM_W = 8;
    localparam logic [15:0] LANE_FLAGS_RST = 16'hffff;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;
    localparam logic [1:0] MODE_RST = 2'h1;

    typedef struct packed {
        logic a_valid;
        logic [7:0] a_trim;
        logic b_valid;
        logic [7:0] b_trim;
    } lfa_trim_t;
endpackage

// ===== core/lfa_regs.sv
/*
 * Register slice: per-lane FIFO error flags with summary bit, interrupt
 * status/mask, and dual-channel sampling trim for cores A and B.
 * Assumes APB on pclk; lane error inputs are level conditions from
 * another domain and are synchronised here; trim defaults arrive as
 * factory values held stable by the caller at and after reset release.
 */
`timescale 1ns/100ps
module lfa_regs #(
    parameter int LANES = 16,
    parameter int TRIM_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [LANES-1:0] lane_fifo_err,
    input wire logic [LANES-1:0] lane_active,
    input wire logic [TRIM_W-1:0] factory_trim_a,
    input wire logic [TRIM_W-1:0] factory_trim_b,
    output lfa_pkg::lfa_trim_t trim_out,
    output logic fifo_error_summary_bit,
    output logic irq
);
    logic wr_stb;
    logic rd_stb;
    logic [11:0] idx;
    logic [LANES-1:0] err_meta_q;
    logic [LANES-1:0] err_sync_q;
    logic [LANES-1:0] lane_flags_q;
    logic summary_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic [1:0] mode_q;
    logic [TRIM_W-1:0] trim_a_q;
    logic [TRIM_W-1:0] trim_b_q;
    logic trim_loaded_q;
    logic lane_evt;
    logic summary_evt;
    logic [31:0] rdata_d;
    logic [31:0] prdata_q;

    // Bus front end
    lfa_apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(pready),
        .pslverr(pslverr),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .idx(idx)
    );

    // Two-stage synchroniser on lane error levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_meta_q <= '0;
            err_sync_q <= '0;
        end else begin
            err_meta_q <= lane_fifo_err;
            err_sync_q <= err_meta_q;
        end
    end

    // Per-lane sticky flags, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lane_flags_q <= lfa_pkg::LANE_FLAGS_RST;
        end else begin
            for (int i = 0; i < LANES; i++) begin
                if (err_sync_q[i]) begin
                    lane_flags_q[i] <= 1'b1;
                end else if (wr_stb && idx == lfa_pkg::IDX_SUMMARY &&
                        pwdata[lfa_pkg::SUMMARY_FIFO_BIT]) begin
                    lane_flags_q[i] <= 1'b0;
                end else if (wr_stb && idx == lfa_pkg::IDX_LANE_FLAGS &&
                        pwdata[i]) begin
                    lane_flags_q[i] <= 1'b0;
                end
            end
        end
    end

    // Summary FIFO alarm bit, set by any active lane error
    assign summary_evt = |(err_sync_q & lane_active);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            summary_q <= 1'b1;
        end else if (summary_evt) begin
            summary_q <= 1'b1;
        end else if (wr_stb && idx == lfa_pkg::IDX_SUMMARY &&
                pwdata[lfa_pkg::SUMMARY_FIFO_BIT]) begin
            summary_q <= 1'b0;
        end
    end
    assign fifo_error_summary_bit = summary_q;

    // Interrupt status: sticky, cleared by reading it
    assign lane_evt = |err_sync_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= '0;
        end else begin
            if (lane_evt) begin
                irq_stat_q[lfa_pkg::IRQ_LANE_BIT] <= 1'b1;
            end else if (rd_stb && idx == lfa_pkg::IDX_IRQ_STATUS) begin
                irq_stat_q[lfa_pkg::IRQ_LANE_BIT] <= 1'b0;
            end
            if (summary_evt) begin
                irq_stat_q[lfa_pkg::IRQ_SUMMARY_BIT] <= 1'b1;
            end else if (rd_stb && idx == lfa_pkg::IDX_IRQ_STATUS) begin
                irq_stat_q[lfa_pkg::IRQ_SUMMARY_BIT] <= 1'b0;
            end
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // Mask and mode control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_q <= lfa_pkg::IRQ_MASK_RST;
            mode_q <= lfa_pkg::MODE_RST;
        end else if (wr_stb) begin
            if (idx == lfa_pkg::IDX_IRQ_MASK) begin
                irq_mask_q <= pwdata[1:0];
            end else if (idx == lfa_pkg::IDX_MODE) begin
                mode_q <= pwdata[1:0];
            end
        end
    end

    // Trim registers: factory load after reset release, then software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_a_q <= '0;
            trim_b_q <= '0;
            trim_loaded_q <= 1'b0;
        end else if (!trim_loaded_q) begin
            trim_a_q <= factory_trim_a;
            trim_b_q <= factory_trim_b;
            trim_loaded_q <= 1'b1;
        end else if (wr_stb) begin
            if (idx == lfa_pkg::IDX_TRIM_A) begin
                trim_a_q <= pwdata[TRIM_W-1:0];
            end else if (idx == lfa_pkg::IDX_TRIM_B) begin
                trim_b_q <= pwdata[TRIM_W-1:0];
            end
        end
    end

    // Trim delivery gated by operating mode
    always_comb begin
        trim_out.a_trim = trim_a_q;
        trim_out.b_trim = trim_b_q;
        trim_out.a_valid = mode_q[lfa_pkg::MODE_DUAL_BIT];
        trim_out.b_valid = mode_q[lfa_pkg::MODE_DUAL_BIT] &
            mode_q[lfa_pkg::MODE_FGCAL_BIT];
    end

    // Read mux; unmapped reads return zero
    always_comb begin
        rdata_d = '0;
        if (idx == lfa_pkg::IDX_LANE_FLAGS) begin
            rdata_d[LANES-1:0] = lane_flags_q;
        end else if (idx == lfa_pkg::IDX_SUMMARY) begin
            rdata_d[lfa_pkg::SUMMARY_FIFO_BIT] = summary_q;
        end else if (idx == lfa_pkg::IDX_TRIM_A) begin
            rdata_d[TRIM_W-1:0] = trim_a_q;
        end else if (idx == lfa_pkg::IDX_TRIM_B) begin
            rdata_d[TRIM_W-1:0] = trim_b_q;
        end else if (idx == lfa_pkg::IDX_IRQ_STATUS) begin
            rdata_d[1:0] = irq_stat_q;
        end else if (idx == lfa_pkg::IDX_IRQ_MASK) begin
            rdata_d[1:0] = irq_mask_q;
        end else if (idx == lfa_pkg::IDX_MODE) begin
            rdata_d[1:0] = mode_q;
        end
    end

    // Read data registered in setup phase, valid in access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (psel && !penable) begin
            prdata_q <= rdata_d;
        end
    end
    assign prdata = prdata_q;
endmodule

// ===== sim/lane_fifo_alarm_and_sample_timing_tb_top.sv
/* Bench for lfa_regs over APB.
   Assumes a zero-wait slave and the checker bound below. */
`timescale 1ns/100ps
module lane_fifo_alarm_and_sample_timing_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, sum_bit, irq;
    logic [13:0] paddr = 14'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [15:0] err = 16'h0, act = 16'hffff;
    logic [7:0] fa = 8'h5a, fb = 8'ha5;
    lfa_pkg::lfa_trim_t trim_out;
    int bad_count = 0, checks = 0;
    // Clock
    always #25 pclk = ~pclk;
    lfa_regs lfa_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lane_fifo_err(err), .lane_active(act), .factory_trim_a(fa),
        .factory_trim_b(fb), .trim_out(trim_out),
        .fifo_error_summary_bit(sum_bit), .irq(irq));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready
    task xfer(input logic w, input logic [11:0] i, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rd(input logic [11:0] i, input logic [31:0] exp);
        xfer(1'b0, i, 32'h0);
        chk(prdata, exp);
    endtask
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        #200000;
        bad_count++;
        report_and_stop;
    end
    // Tests
    initial begin
        wt(12);
        presetn <= 1'b1;
        wt(3);
        rd(lfa_pkg::IDX_LANE_FLAGS, 32'hffff);
        rd(lfa_pkg::IDX_SUMMARY, 32'h20);
        rd(lfa_pkg::IDX_TRIM_A, 32'h5a);
        rd(lfa_pkg::IDX_TRIM_B, 32'ha5);
        rd(lfa_pkg::IDX_IRQ_MASK, 32'h0);
        rd(lfa_pkg::IDX_MODE, 32'h1);
        rd(12'h000, 32'h0);
        $display("test reset done");
        xfer(1'b1, lfa_pkg::IDX_LANE_FLAGS, 32'h00ff);
        rd(lfa_pkg::IDX_LANE_FLAGS, 32'hff00);
        xfer(1'b1, lfa_pkg::IDX_LANE_FLAGS, 32'hff00);
        rd(lfa_pkg::IDX_LANE_FLAGS, 32'h0);
        err <= 16'h0008;
        wt(5);
        err <= 16'h0;
        wt(4);
        rd(lfa_pkg::IDX_LANE_FLAGS, 32'h8);
        xfer(1'b1, lfa_pkg::IDX_SUMMARY, 32'h20);
        rd(lfa_pkg::IDX_LANE_FLAGS, 32'h0);
        rd(lfa_pkg::IDX_SUMMARY, 32'h0);
        $display("test clear done");
        err <= 16'h0080;
        wt(5);
        xfer(1'b1, lfa_pkg::IDX_LANE_FLAGS, 32'h80);
        rd(lfa_pkg::IDX_LANE_FLAGS, 32'h80);
        err <= 16'h0;
        wt(4);
        xfer(1'b1, lfa_pkg::IDX_LANE_FLAGS, 32'h80);
        rd(lfa_pkg::IDX_LANE_FLAGS, 32'h0);
        $display("test persist done");
        xfer(1'b1, lfa_pkg::IDX_SUMMARY, 32'h20);
        rd(lfa_pkg::IDX_IRQ_STATUS, 32'h3);
        rd(lfa_pkg::IDX_IRQ_STATUS, 32'h0);
        err <= 16'h0002;
        wt(2);
        err <= 16'h0;
        wt(4);
        chk(32'(irq), 32'h0);
        xfer(1'b1, lfa_pkg::IDX_IRQ_MASK, 32'h3);
        wt(1);
        chk(32'(irq), 32'h1);
        rd(lfa_pkg::IDX_IRQ_STATUS, 32'h3);
        wt(1);
        chk(32'(irq), 32'h0);
        $display("test irq done");
        xfer(1'b1, lfa_pkg::IDX_TRIM_A, 32'h3c);
        rd(lfa_pkg::IDX_TRIM_A, 32'h3c);
        xfer(1'b1, lfa_pkg::IDX_TRIM_B, 32'h1c3);
        rd(lfa_pkg::IDX_TRIM_B, 32'hc3);
        for (int m = 0; m < 4; m++) begin
            xfer(1'b1, lfa_pkg::IDX_MODE, 32'(m));
            wt(1);
            chk(32'(trim_out.a_valid), 32'(m % 2));
            chk(32'(trim_out.b_valid), 32'(m == 3));
        end
        $display("test trim done");
        // Inactive lanes set their flag but not the summary bit
        xfer(1'b1, lfa_pkg::IDX_SUMMARY, 32'h20);
        wt(1);
        chk(32'(sum_bit), 32'h0);
        act <= 16'hfffe;
        err <= 16'h0001;
        wt(5);
        err <= 16'h0;
        wt(4);
        chk(32'(sum_bit), 32'h0);
        rd(lfa_pkg::IDX_LANE_FLAGS, 32'h1);
        chk(32'({pready, pslverr}), 32'h2);
        chk(32'(trim_out.a_trim), 32'h3c);
        chk(32'(trim_out.b_trim), 32'hc3);
        act <= 16'hffff;
        err <= 16'h0002;
        wt(5);
        err <= 16'h0;
        wt(4);
        chk(32'(sum_bit), 32'h1);
        rd(lfa_pkg::IDX_LANE_FLAGS, 32'h3);
        $display("test active done");
        report_and_stop;
    end
endmodule
// Checker on the design's ports
bind lfa_regs lfa_regs_props #(.LANES(LANES), .TRIM_W(TRIM_W)) lfa_regs_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lane_fifo_err(lane_fifo_err),
    .lane_active(lane_active), .factory_trim_a(factory_trim_a),
    .factory_trim_b(factory_trim_b), .trim_out(trim_out),
    .fifo_error_summary_bit(fifo_error_summary_bit), .irq(irq));

// ===== sim/lfa_regs_props.sv
/* Port checker for lfa_regs.
   Assumes a bind onto lfa_regs and the single pclk domain. */
`timescale 1ns/100ps
module lfa_regs_props #(
    parameter int LANES = 16,
    parameter int TRIM_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [LANES-1:0] lane_fifo_err,
    input wire logic [LANES-1:0] lane_active,
    input wire logic [TRIM_W-1:0] factory_trim_a,
    input wire logic [TRIM_W-1:0] factory_trim_b,
    input wire lfa_pkg::lfa_trim_t trim_out,
    input wire logic fifo_error_summary_bit,
    input wire logic irq
);
    logic [1:0] age_q;
    logic acc, err_any, sum_clr, wa, wb, wm;
    // Write decode per register, and the active-lane error term
    assign acc = psel && penable && pwrite;
    assign err_any = |(lane_fifo_err & lane_active);
    assign sum_clr = acc && paddr[13:2] == lfa_pkg::IDX_SUMMARY && pwdata[5];
    assign wa = acc && paddr[13:2] == lfa_pkg::IDX_TRIM_A;
    assign wb = acc && paddr[13:2] == lfa_pkg::IDX_TRIM_B;
    assign wm = acc && paddr[13:2] == lfa_pkg::IDX_MODE;
    // Edges since reset release, saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) age_q <= 2'h0;
        else if (age_q != 2'h3) age_q <= age_q + 2'h1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Error seen, then through the sync stages
    sequence err_seen;
        err_any ##3 1'b1;
    endsequence
    sum_set_a: assert property (err_seen |-> fifo_error_summary_bit)
        else $error("summary bit missed an error");
    sum_clr_a: assert property (sum_clr && !$past(err_any, 2)
        |=> !fifo_error_summary_bit) else $error("summary not cleared");
    sum_hold_a: assert property (fifo_error_summary_bit && !sum_clr
        |=> fifo_error_summary_bit) else $error("summary dropped");
    sum_rst_a: assert property (age_q == 2'h0
        |-> fifo_error_summary_bit && !irq) else $error("bad reset state");
    trim_load_a: assert property (age_q == 2'h1
        |-> trim_out.a_trim == factory_trim_a && trim_out.b_trim == factory_trim_b)
        else $error("factory trim not loaded");
    a_wr_a: assert property (wa |=> trim_out.a_trim == $past(pwdata[7:0]))
        else $error("trim a write lost");
    b_wr_a: assert property (wb |=> trim_out.b_trim == $past(pwdata[7:0]))
        else $error("trim b write lost");
    a_hold_a: assert property (age_q != 2'h0 && !wa
        |=> $stable(trim_out.a_trim)) else $error("trim a moved");
    mode_a: assert property (wm |=> trim_out.a_valid == $past(pwdata[0]) &&
        trim_out.b_valid == &$past(pwdata[1:0])) else $error("bad valids");
endmodule
